/* File: src/port_pad_ctrl.sv */
// Port C pad control: AHB-Lite register slave plus eight pad cells.
// Assumes synchronous pad inputs and a single-slave AHB-Lite bus on SYS_CLK.
//
// Operation
// - Pull-enable bit pulls only input pins
// - Driven pins never get a pull
// - Analog-owned pins never get a pull
// - Rising keyboard pins 4,5 pull down instead
// - Slew limit acts on outputs only
// - Drive bit: 0 low, 1 high, outputs only
// - Data bit 7 reads input-only pin level
// - Data bit 6 reads the stored latch
// - Direction bits 6,7 ignored by fixed pins
// - Pull bits 6 and 7 do nothing
// - Slew and drive bit 7 do nothing
// - Control writes leave data and direction alone
// - Direction 0 input, 1 driven latch readback
// - Reset clears latch, pins other than 6 float, no pull
`default_nettype none

module port_pad_ctrl
  import port_pad_pkg::*;
#(
  parameter int PORT_WIDTH = PORT_PINS
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [PORT_WIDTH-1:0] PAD_IN,
  output logic [PORT_WIDTH-1:0] PAD_OUT,
  output logic [PORT_WIDTH-1:0] PAD_OE,
  output logic [PORT_WIDTH-1:0] PAD_PULLUP,
  output logic [PORT_WIDTH-1:0] PAD_PULLDOWN,
  output logic [PORT_WIDTH-1:0] PAD_SLEW,
  output logic [PORT_WIDTH-1:0] PAD_DRIVE_HI,
  input wire logic [PORT_WIDTH-1:0] PERIPH_OE,
  input wire logic [PORT_WIDTH-1:0] PERIPH_OUT,
  input wire logic [PORT_WIDTH-1:0] ANALOG_OWN,
  input wire logic [PORT_WIDTH-1:0] KBI_PIN_EN,
  input wire logic [PORT_WIDTH-1:0] KBI_RISING
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Fixed-direction pin positions assume an eight-pin port
  if (PORT_WIDTH != PORT_PINS) begin : g_bad_width
    $error("port_pad_ctrl: PORT_WIDTH must be 8");
  end

  // Fixed pins must sit inside the port
  if (INPUT_ONLY_IDX >= PORT_WIDTH || OUTPUT_ONLY_IDX >= PORT_WIDTH) begin : g_bad_pins
    $error("port_pad_ctrl: fixed pin index outside the port");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] widen(input logic [PORT_WIDTH-1:0] v);
    widen = {{(32 - PORT_WIDTH){1'b0}}, v};
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [PORT_WIDTH-1:0] pin_data_latch_r;
  logic [PORT_WIDTH-1:0] pin_direction_r;
  logic [PORT_WIDTH-1:0] pull_resistor_enable_r;
  logic [PORT_WIDTH-1:0] slew_limit_enable_r;
  logic [PORT_WIDTH-1:0] drive_strength_select_r;

  // Bus state
  bus_state_t bus_state_r;
  logic [7:0] addr_r;
  logic write_r;
  logic in_range_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // Pad outputs
  logic [PORT_WIDTH-1:0] pad_out_r;
  logic [PORT_WIDTH-1:0] pad_oe_r;
  logic [PORT_WIDTH-1:0] pad_pullup_r;
  logic [PORT_WIDTH-1:0] pad_pulldown_r;
  logic [PORT_WIDTH-1:0] pad_slew_r;
  logic [PORT_WIDTH-1:0] pad_drive_r;

  // Cell outputs
  logic [PORT_WIDTH-1:0] oe_nxt;
  logic [PORT_WIDTH-1:0] out_nxt;
  logic [PORT_WIDTH-1:0] pullup_nxt;
  logic [PORT_WIDTH-1:0] pulldown_nxt;
  logic [PORT_WIDTH-1:0] slew_nxt;
  logic [PORT_WIDTH-1:0] drive_nxt;
  logic [PORT_WIDTH-1:0] data_rd;

  // Decode
  logic addr_take;
  logic do_access;
  logic do_write;
  logic [31:0] hrdata_nxt;
  logic [PORT_WIDTH-1:0] wr_byte;
  logic wr_latch;
  logic wr_dir;
  logic wr_pull;
  logic wr_slew;
  logic wr_drive;

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  // Every NONSEQ transfer gets one wait state so read data can come from a flop
  assign addr_take = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);
  assign do_access = (bus_state_r == BUS_WAIT);
  assign do_write = do_access & write_r & in_range_r;
  assign wr_byte = HWDATA[PORT_WIDTH-1:0];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      bus_state_r <= BUS_IDLE;
      addr_r <= 8'h00;
      write_r <= 1'b0;
      in_range_r <= 1'b0;
    end else begin
      case (bus_state_r)
        BUS_IDLE: begin
          if (addr_take) begin
            bus_state_r <= BUS_WAIT;
            addr_r <= HADDR[7:0];
            write_r <= HWRITE;
            // Only aligned word accesses in the first 256 bytes hit a register
            in_range_r <= (HADDR[31:8] == 24'h000000) & (HADDR[1:0] == 2'h0)
              & (HSIZE == HSIZE_WORD);
          end
        end
        BUS_WAIT: begin
          bus_state_r <= BUS_IDLE;
        end
        default: begin
          bus_state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= ~((bus_state_r == BUS_IDLE) & addr_take);
      hresp_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // One strobe per register, so a control write never reaches data or direction
  assign wr_latch = do_write & addr_is(addr_r, OFS_PIN_DATA_LATCH);
  assign wr_dir = do_write & addr_is(addr_r, OFS_PIN_DIRECTION);
  assign wr_pull = do_write & addr_is(addr_r, OFS_PULL_RESISTOR_ENABLE);
  assign wr_slew = do_write & addr_is(addr_r, OFS_SLEW_LIMIT_ENABLE);
  assign wr_drive = do_write & addr_is(addr_r, OFS_DRIVE_STRENGTH_SELECT);

  // ----------------------------------------------------------------
  // Data and direction registers
  // ----------------------------------------------------------------
  // Written only at their own offsets, never by control writes
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pin_data_latch_r <= RST_PIN_DATA_LATCH;
    end else if (wr_latch) begin
      pin_data_latch_r <= wr_byte;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pin_direction_r <= RST_PIN_DIRECTION;
    end else if (wr_dir) begin
      pin_direction_r <= wr_byte;
    end
  end

  // ----------------------------------------------------------------
  // Pad control registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pull_resistor_enable_r <= RST_PULL_RESISTOR_ENABLE;
    end else if (wr_pull) begin
      pull_resistor_enable_r <= wr_byte;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      slew_limit_enable_r <= RST_SLEW_LIMIT_ENABLE;
    end else if (wr_slew) begin
      slew_limit_enable_r <= wr_byte;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      drive_strength_select_r <= RST_DRIVE_STRENGTH_SELECT;
    end else if (wr_drive) begin
      drive_strength_select_r <= wr_byte;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped or misaligned reads return zero with an OKAY answer
  // Status words are read-only; writes to them have no strobe
  always_comb begin
    hrdata_nxt = 32'h00000000;
    if (!in_range_r) begin
      hrdata_nxt = 32'h00000000;
    end else if (addr_is(addr_r, OFS_PIN_DATA_LATCH)) begin
      hrdata_nxt = widen(data_rd);
    end else if (addr_is(addr_r, OFS_PIN_DIRECTION)) begin
      hrdata_nxt = widen(pin_direction_r);
    end else if (addr_is(addr_r, OFS_PULL_RESISTOR_ENABLE)) begin
      hrdata_nxt = widen(pull_resistor_enable_r);
    end else if (addr_is(addr_r, OFS_SLEW_LIMIT_ENABLE)) begin
      hrdata_nxt = widen(slew_limit_enable_r);
    end else if (addr_is(addr_r, OFS_DRIVE_STRENGTH_SELECT)) begin
      hrdata_nxt = widen(drive_strength_select_r);
    end else if (addr_is(addr_r, OFS_PAD_OUTPUT_ENABLE_STATUS)) begin
      hrdata_nxt = widen(pad_oe_r);
    end else if (addr_is(addr_r, OFS_PAD_PULLUP_STATUS)) begin
      hrdata_nxt = widen(pad_pullup_r);
    end else if (addr_is(addr_r, OFS_PAD_PULLDOWN_STATUS)) begin
      hrdata_nxt = widen(pad_pulldown_r);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      hrdata_r <= 32'h00000000;
    end else if (do_access & ~write_r) begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pad cells
  // ----------------------------------------------------------------
  // Pins 6 and 7 get fixed-direction cells
  for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pad
    port_pad_cell #(
      .INPUT_ONLY(i == INPUT_ONLY_IDX),
      .OUTPUT_ONLY(i == OUTPUT_ONLY_IDX),
      .PULL_CAPABLE(PULL_CAPABLE_MASK[i]),
      .KBI_PULLDOWN(KBI_PULLDOWN_MASK[i])
    ) u_cell (
      .dir(pin_direction_r[i]),
      .latch(pin_data_latch_r[i]),
      .periph_oe(PERIPH_OE[i]),
      .periph_out(PERIPH_OUT[i]),
      .analog_own(ANALOG_OWN[i]),
      .kbi_en(KBI_PIN_EN[i]),
      .kbi_rise(KBI_RISING[i]),
      .pull_en(pull_resistor_enable_r[i]),
      .slew_en(slew_limit_enable_r[i]),
      .drive_hi(drive_strength_select_r[i]),
      .pad_in(PAD_IN[i]),
      .oe(oe_nxt[i]),
      .out(out_nxt[i]),
      .pull_up_en(pullup_nxt[i]),
      .pull_down_en(pulldown_nxt[i]),
      .slew(slew_nxt[i]),
      .drive(drive_nxt[i]),
      .rd_bit(data_rd[i])
    );
  end

  // ----------------------------------------------------------------
  // Pad output registers
  // ----------------------------------------------------------------
  // One cycle of lag to the pads, traded for glitch-free pad controls
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pad_oe_r <= '0;
      pad_out_r <= '0;
    end else begin
      pad_oe_r <= oe_nxt;
      pad_out_r <= out_nxt;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pad_pullup_r <= '0;
      pad_pulldown_r <= '0;
    end else begin
      pad_pullup_r <= pullup_nxt;
      pad_pulldown_r <= pulldown_nxt;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pad_slew_r <= '0;
      pad_drive_r <= '0;
    end else begin
      pad_slew_r <= slew_nxt;
      pad_drive_r <= drive_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HRDATA = hrdata_r;
  assign HREADYOUT = hreadyout_r;
  assign HRESP = hresp_r;
  assign PAD_OUT = pad_out_r;
  assign PAD_OE = pad_oe_r;
  assign PAD_PULLUP = pad_pullup_r;
  assign PAD_PULLDOWN = pad_pulldown_r;
  assign PAD_SLEW = pad_slew_r;
  assign PAD_DRIVE_HI = pad_drive_r;

endmodule

`default_nettype wire

/* File: src/port_pad_pkg.sv */
// Package for the port C pad control block: offsets, field layout, reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`default_nettype none

package port_pad_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PORT_PINS = 8;
  localparam int INPUT_ONLY_IDX = 7;
  localparam int OUTPUT_ONLY_IDX = 6;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_DATA_LATCH = 8'h00;
  localparam logic [7:0] OFS_PIN_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_PULL_RESISTOR_ENABLE = 8'h08;
  localparam logic [7:0] OFS_SLEW_LIMIT_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_DRIVE_STRENGTH_SELECT = 8'h10;
  localparam logic [7:0] OFS_PAD_OUTPUT_ENABLE_STATUS = 8'h14;
  localparam logic [7:0] OFS_PAD_PULLUP_STATUS = 8'h18;
  localparam logic [7:0] OFS_PAD_PULLDOWN_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PIN_DATA_LATCH = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
  localparam logic [7:0] RST_PULL_RESISTOR_ENABLE = 8'h00;
  localparam logic [7:0] RST_SLEW_LIMIT_ENABLE = 8'h00;
  localparam logic [7:0] RST_DRIVE_STRENGTH_SELECT = 8'h00;

  // ----------------------------------------------------------------
  // Per-pin capability masks
  // ----------------------------------------------------------------
  localparam logic [7:0] PULL_CAPABLE_MASK = 8'h3F;
  localparam logic [7:0] KBI_PULLDOWN_MASK = 8'hB0;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [0:0] {BUS_IDLE, BUS_WAIT} bus_state_t;

endpackage

`default_nettype wire

/* File: src/port_pad_cell.sv */
// One pad's control logic: direction, pull, slew and drive gating.
// Assumes the owning port registers its outputs; this cell is pure logic.
`default_nettype none

module port_pad_cell #(
  parameter bit INPUT_ONLY = 1'b0,
  parameter bit OUTPUT_ONLY = 1'b0,
  parameter bit PULL_CAPABLE = 1'b1,
  parameter bit KBI_PULLDOWN = 1'b0
) (
  input wire logic dir,
  input wire logic latch,
  input wire logic periph_oe,
  input wire logic periph_out,
  input wire logic analog_own,
  input wire logic kbi_en,
  input wire logic kbi_rise,
  input wire logic pull_en,
  input wire logic slew_en,
  input wire logic drive_hi,
  input wire logic pad_in,
  output logic oe,
  output logic out,
  output logic pull_up_en,
  output logic pull_down_en,
  output logic slew,
  output logic drive,
  output logic rd_bit
);

  logic port_drives;
  logic any_drive;
  logic pull_on;
  logic down_sel;

  // ----------------------------------------------------------------
  // Direction
  // ----------------------------------------------------------------
  // Fixed-direction pins ignore the stored direction bit
  always_comb begin
    if (INPUT_ONLY) begin
      port_drives = 1'b0;
    end else if (OUTPUT_ONLY) begin
      port_drives = 1'b1;
    end else begin
      port_drives = dir;
    end
  end

  assign any_drive = (port_drives | periph_oe) & ~INPUT_ONLY & ~analog_own;
  assign oe = any_drive;
  assign out = periph_oe ? periph_out : latch;

  // ----------------------------------------------------------------
  // Pull resistor
  // ----------------------------------------------------------------
  // Pull only on an undriven, digital input
  assign pull_on = PULL_CAPABLE & pull_en & ~port_drives
    & ~periph_oe & ~analog_own;
  assign down_sel = KBI_PULLDOWN & kbi_en & kbi_rise;
  assign pull_up_en = pull_on & ~down_sel;
  assign pull_down_en = pull_on & down_sel;

  // ----------------------------------------------------------------
  // Output shaping
  // ----------------------------------------------------------------
  assign slew = slew_en & any_drive;
  assign drive = drive_hi & any_drive;

  // ----------------------------------------------------------------
  // Data read
  // ----------------------------------------------------------------
  always_comb begin
    if (INPUT_ONLY) begin
      rd_bit = pad_in;
    end else if (OUTPUT_ONLY) begin
      rd_bit = latch;
    end else begin
      rd_bit = dir ? latch : pad_in;
    end
  end

endmodule

`default_nettype wire

/* File: verification/port_pad_ctrl_assertions.sv */
// Checker for the port pad controller: pad gating and bus wait timing.
// Assumes it is bound onto port_pad_ctrl on a single-slave bus.
`default_nettype none

module port_pad_ctrl_assertions
  import port_pad_pkg::*;
#(
  parameter int PORT_WIDTH = PORT_PINS
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [PORT_WIDTH-1:0] PAD_OE,
  input wire logic [PORT_WIDTH-1:0] PAD_PULLUP,
  input wire logic [PORT_WIDTH-1:0] PAD_PULLDOWN,
  input wire logic [PORT_WIDTH-1:0] PAD_SLEW,
  input wire logic [PORT_WIDTH-1:0] PAD_DRIVE_HI,
  input wire logic [PORT_WIDTH-1:0] PERIPH_OE,
  input wire logic [PORT_WIDTH-1:0] ANALOG_OWN,
  input wire logic [PORT_WIDTH-1:0] KBI_PIN_EN,
  input wire logic [PORT_WIDTH-1:0] KBI_RISING
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Helpers
  // ----
  // Pad outputs lag their cause by one clock, hence the past values
  logic an6;
  assign an6 = ANALOG_OWN[OUTPUT_ONLY_IDX];
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence addr_taken;
    HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
  endsequence
  sequence one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  // ----
  // Properties
  // ----
  a_bus_one_wait: assert property (addr_taken |=> one_wait)
    else $error("bus wait state wrong");
  a_bad_read_zero: assert property (addr_taken and HADDR == 32'h20 && !HWRITE |=> ##1 HRDATA == 0)
    else $error("unmapped read not zero");
  a_resp_always_okay: assert property (HRESP == 1'b0) else $error("response not okay");
  a_no_pull_driven: assert property (((PAD_PULLUP | PAD_PULLDOWN) & PAD_OE) == 0)
    else $error("pull on driven pin");
  a_periph_no_pull: assert property (((PAD_PULLUP | PAD_PULLDOWN) & $past(PERIPH_OE)) == 0)
    else $error("pull on peripheral pin");
  a_analog_all_off: assert property (((PAD_PULLUP | PAD_PULLDOWN | PAD_SLEW | PAD_DRIVE_HI)
    & $past(ANALOG_OWN)) == 0) else $error("analog pin not released");
  a_slew_outputs: assert property ((PAD_SLEW & ~PAD_OE) == 0)
    else $error("slew on input pin");
  a_drive_outputs: assert property ((PAD_DRIVE_HI & ~PAD_OE) == 0)
    else $error("drive on input pin");
  a_pin7_input: assert property (!PAD_OE[INPUT_ONLY_IDX] && !PAD_SLEW[INPUT_ONLY_IDX])
    else $error("input pin driven");
  a_pin6_driven: assert property ($past(RST_N) && !$past(an6) |-> PAD_OE[OUTPUT_ONLY_IDX])
    else $error("output pin not driven");
  a_pullup_pins: assert property ((PAD_PULLUP & ~PULL_CAPABLE_MASK) == 0)
    else $error("pull on fixed pin");
  a_kbi_pulldown: assert property ((PAD_PULLDOWN & ~($past(KBI_PIN_EN)
    & $past(KBI_RISING) & 8'h30)) == 0) else $error("stray pulldown");
  a_kbi_no_pullup: assert property ((PAD_PULLUP & $past(KBI_PIN_EN)
    & $past(KBI_RISING) & 8'h30) == 0) else $error("pullup on rising key pin");
endmodule

bind port_pad_ctrl port_pad_ctrl_assertions #(.PORT_WIDTH(PORT_WIDTH)) u_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .PAD_OE(PAD_OE), .PAD_PULLUP(PAD_PULLUP), .PAD_PULLDOWN(PAD_PULLDOWN),
  .PAD_SLEW(PAD_SLEW), .PAD_DRIVE_HI(PAD_DRIVE_HI), .PERIPH_OE(PERIPH_OE),
  .ANALOG_OWN(ANALOG_OWN), .KBI_PIN_EN(KBI_PIN_EN), .KBI_RISING(KBI_RISING));

`default_nettype wire

/* File: verification/pad_world.sv */
// Model of the board around the eight pads: drivers, pulls, floating lines.
// Assumes the bench chooses which pins an outside source drives.
`default_nettype none

module pad_world (
  input wire logic clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] pad_pulldown,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Floating pins wander every cycle so no test leans on a stale level
  logic [7:0] float_r = 8'h55;
  always_ff @(posedge clk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup[i]) pad_in[i] = 1'b1;
      else if (pad_pulldown[i]) pad_in[i] = 1'b0;
      else pad_in[i] = float_r[i];
    end
  end
endmodule

`default_nettype wire

/* File: verification/tb_port_pad_ctrl.sv */
// Testbench for the port pad controller: register bus, pad gating, readback.
// Assumes the design, its package, the pad model and the bound checker.
`default_nettype none

module tb_port_pad_ctrl
  import port_pad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_slew, pad_drv;
  logic [7:0] per_oe, per_out, ana, kbi_en, kbi_rise, ext_en, ext_val;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 clk = ~clk;

  port_pad_ctrl i_dut (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULLUP(pad_pu), .PAD_PULLDOWN(pad_pd),
    .PAD_SLEW(pad_slew), .PAD_DRIVE_HI(pad_drv), .PERIPH_OE(per_oe), .PERIPH_OUT(per_out),
    .ANALOG_OWN(ana), .KBI_PIN_EN(kbi_en), .KBI_RISING(kbi_rise));
  pad_world i_world (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu),
    .pad_pulldown(pad_pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // ----
  // Shared tasks
  // ----
  task automatic print_verdict;
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // No fixed latency assumed: each phase waits for ready, the watchdog cuts hangs
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(a, 1'b1, d, dummy);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    xfer(a, 1'b0, 32'h0, v);
    chk(n, v, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rdchk("reset_reg", 8'(4 * i), 32'h0);
    chk("oe", pad_oe, 8'h40);
    chk("pads", {pad_out, pad_pu, pad_pd, pad_slew | pad_drv}, 32'h0);
  endtask
  task automatic t_pull;
    wr(OFS_PIN_DIRECTION, 32'h0F);
    wr(OFS_PULL_RESISTOR_ENABLE, 32'hFF);
    settle;
    chk("pullup", pad_pu, 8'h30);
    per_oe <= 8'h20;
    settle;
    chk("pullup", pad_pu, 8'h10);
    per_oe <= 8'h00;
    ana <= 8'h10;
    settle;
    chk("pullup", pad_pu, 8'h20);
    ana <= 8'h00;
    kbi_en <= 8'hB0;
    kbi_rise <= 8'h90;
    settle;
    chk("pull", {pad_pu, pad_pd}, 16'h2010);
    kbi_rise <= 8'hB0;
    settle;
    rdchk("pulldown_status", OFS_PAD_PULLDOWN_STATUS, 32'h30);
    rdchk("pullup_status", OFS_PAD_PULLUP_STATUS, 32'h00);
    kbi_en <= 8'h00;
  endtask
  task automatic t_slew;
    wr(OFS_SLEW_LIMIT_ENABLE, 32'hFF);
    wr(OFS_DRIVE_STRENGTH_SELECT, 32'h8F);
    per_oe <= 8'h10;
    settle;
    chk("slew", pad_slew, 8'h5F);
    chk("drive", pad_drv, 8'h0F);
    wr(OFS_DRIVE_STRENGTH_SELECT, 32'h70);
    ana <= 8'h40;
    settle;
    chk("drive", pad_drv, 8'h10);
    chk("slew", pad_slew, 8'h1F);
    per_oe <= 8'h00;
    ana <= 8'h00;
  endtask
  task automatic t_data;
    wr(OFS_PIN_DIRECTION, 32'hFF);
    wr(OFS_PIN_DATA_LATCH, 32'hC5);
    per_oe <= 8'h01;
    ext_val <= 8'h00;
    settle;
    chk("oe", pad_oe, 8'h7F);
    chk("out", pad_out & 8'h7F, 8'h44);
    rdchk("data", OFS_PIN_DATA_LATCH, 32'h45);
    per_oe <= 8'h00;
    wr(OFS_PIN_DIRECTION, 32'h00);
    ext_val <= 8'hAA;
    settle;
    chk("oe", pad_oe, 8'h40);
    rdchk("data", OFS_PIN_DATA_LATCH, 32'hEA);
    wr(OFS_PULL_RESISTOR_ENABLE, 32'h00);
    wr(OFS_SLEW_LIMIT_ENABLE, 32'h00);
    wr(OFS_DRIVE_STRENGTH_SELECT, 32'hFF);
    rdchk("drive_reg", OFS_DRIVE_STRENGTH_SELECT, 32'hFF);
    rdchk("dir", OFS_PIN_DIRECTION, 32'h00);
    rdchk("data", OFS_PIN_DATA_LATCH, 32'hEA);
  endtask
  task automatic t_bad;
    wr(8'h20, 32'hFF);
    rdchk("unmapped", 8'h20, 32'h0);
    wr(8'h09, 32'hFF);
    // A byte-sized write to a real register must be refused as well
    hsize <= 3'h0;
    wr(OFS_PULL_RESISTOR_ENABLE, 32'hFF);
    hsize <= HSIZE_WORD;
    rdchk("pull_reg", OFS_PULL_RESISTOR_ENABLE, 32'h0);
    rdchk("oe_status", OFS_PAD_OUTPUT_ENABLE_STATUS, 32'h40);
  endtask

  // ----
  // Sequence and watchdog
  // ----
  // Whole run needs about 150 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = HTRANS_IDLE;
    hsize = HSIZE_WORD;
    per_oe = 8'h00;
    per_out = 8'h00;
    ana = 8'h00;
    kbi_en = 8'h00;
    kbi_rise = 8'h00;
    ext_en = 8'hFF;
    ext_val = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_pull;
    t_slew;
    t_data;
    t_bad;
    print_verdict;
  end
endmodule

`default_nettype wire
